/* hw/irt_pkg.sv */
`default_nettype none
package irt_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] OFS_REVISION_ID = 8'h08;
  localparam logic [7:0] OFS_POWER_DOWN_RESET_CTRL = 8'h09;
  localparam logic [7:0] OFS_MISCELLANEOUS_CTRL = 8'h0A;
  localparam logic [7:0] OFS_LEGACY_DATA_SLEW = 8'h0B;
  localparam logic [7:0] OFS_DATA_CLOCK_SLEW = 8'h0C;
  localparam logic [7:0] OFS_GLOBAL_CONFIG = 8'h0D;
  localparam logic [7:0] OFS_EQUALIZER_SELECT = 8'h0E;
  localparam logic [7:0] OFS_LANE_ENABLES = 8'h11;
  localparam logic [7:0] OFS_CLOCK_LANE_SWING_FFE = 8'h12;
  localparam logic [7:0] OFS_CLOCK_LANE_RX_EQ = 8'h13;
  localparam logic [7:0] OFS_LANE0_SWING_FFE = 8'h14;
  localparam logic [7:0] OFS_LANE0_RX_EQ = 8'h15;
  localparam logic [7:0] OFS_LANE1_SWING_FFE = 8'h16;
  localparam logic [7:0] OFS_LANE1_RX_EQ = 8'h17;
  localparam logic [7:0] OFS_LANE2_SWING_FFE = 8'h18;
  localparam logic [7:0] OFS_LANE2_RX_EQ = 8'h19;
  localparam logic [7:0] OFS_SIGNAL_DETECT_THRESHOLD = 8'h1A;
  localparam logic [7:0] OFS_POWER_STANDBY_STATUS = 8'h1C;
  localparam logic [7:0] OFS_ADAPTIVE_EQ_CTRL_A = 8'h1D;
  localparam logic [7:0] OFS_ADAPTIVE_EQ_CTRL_B = 8'h1E;
  localparam logic [7:0] OFS_CLOCK_RATIO_CONFIG = 8'h20;
  localparam logic [7:0] OFS_LINK_RATE_FFE_CONFIG = 8'h31;
  localparam logic [7:0] OFS_SOURCE_TEST_CONFIG = 8'h35;
  localparam logic [7:0] OFS_TRAINING_STATUS_LANES01 = 8'h41;
  localparam logic [7:0] OFS_TRAINING_STATUS_LANES23 = 8'h42;
  localparam logic [7:0] OFS_ADAPTIVE_EQ_RESULT_A = 8'h50;
  localparam logic [7:0] OFS_ADAPTIVE_EQ_RESULT_B = 8'h51;

  ////////////////////////////////////////////////////////////////////////
  // reset values, field positions and write masks
  localparam logic [7:0] RST_POWER_DOWN_RESET_CTRL = 8'h01;
  localparam logic [7:0] RST_MISCELLANEOUS_CTRL = 8'h08;
  localparam logic [7:0] RST_OTHER = 8'h00;
  localparam logic [7:0] RST_POINTER = 8'h00;
  localparam int PD_SOFT_RESET_BIT = 7;
  localparam int PD_SCDC_RESET_BIT = 6;
  localparam logic [7:0] PD_WRITE_MASK = 8'h17;

  ////////////////////////////////////////////////////////////////////////
  // target addresses per strap level (low, pull-down R, float, high)
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_RES = 2'h1;
  localparam logic [1:0] STRAP_FLOAT = 2'h2;
  localparam logic [1:0] STRAP_HIGH = 2'h3;
  localparam logic [6:0] TADDR_LOW = 7'h5E;
  localparam logic [6:0] TADDR_RES = 7'h5D;
  localparam logic [6:0] TADDR_FLOAT = 7'h5C;
  localparam logic [6:0] TADDR_HIGH = 7'h5B;

  // bits per byte on the serial link
  localparam logic [3:0] BYTE_BITS = 4'h8;

  ////////////////////////////////////////////////////////////////////////
  // serial engine states, one-hot
  typedef enum logic [9:0] {
    ST_IDLE      = 10'h001,
    ST_ADDR      = 10'h002,
    ST_ADDR_ACK  = 10'h004,
    ST_OFFS      = 10'h008,
    ST_OFFS_ACK  = 10'h010,
    ST_WDATA     = 10'h020,
    ST_WDATA_ACK = 10'h040,
    ST_RDATA     = 10'h080,
    ST_RACK      = 10'h100,
    ST_WAIT_STOP = 10'h200
  } irt_state_t;

  // write mask per offset: zero for read-only and reserved offsets
  function automatic logic [7:0] irt_wmask(input logic [7:0] a);
    case (a)
      OFS_REVISION_ID, OFS_POWER_STANDBY_STATUS,
      OFS_ADAPTIVE_EQ_RESULT_A, OFS_ADAPTIVE_EQ_RESULT_B: irt_wmask = 8'h00;
      OFS_POWER_DOWN_RESET_CTRL: irt_wmask = PD_WRITE_MASK;
      OFS_MISCELLANEOUS_CTRL, OFS_LEGACY_DATA_SLEW, OFS_DATA_CLOCK_SLEW,
      OFS_GLOBAL_CONFIG, OFS_EQUALIZER_SELECT, OFS_LANE_ENABLES,
      OFS_CLOCK_LANE_SWING_FFE, OFS_CLOCK_LANE_RX_EQ, OFS_LANE0_SWING_FFE,
      OFS_LANE0_RX_EQ, OFS_LANE1_SWING_FFE, OFS_LANE1_RX_EQ,
      OFS_LANE2_SWING_FFE, OFS_LANE2_RX_EQ, OFS_SIGNAL_DETECT_THRESHOLD,
      OFS_ADAPTIVE_EQ_CTRL_A, OFS_ADAPTIVE_EQ_CTRL_B, OFS_CLOCK_RATIO_CONFIG,
      OFS_LINK_RATE_FFE_CONFIG, OFS_SOURCE_TEST_CONFIG,
      OFS_TRAINING_STATUS_LANES01,
      OFS_TRAINING_STATUS_LANES23: irt_wmask = 8'hFF;
      default: irt_wmask = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] irt_reset(input logic [7:0] a);
    case (a)
      OFS_POWER_DOWN_RESET_CTRL: irt_reset = RST_POWER_DOWN_RESET_CTRL;
      OFS_MISCELLANEOUS_CTRL: irt_reset = RST_MISCELLANEOUS_CTRL;
      default: irt_reset = RST_OTHER;
    endcase
  endfunction

  function automatic logic irt_is_link_cfg(input logic [7:0] a);
    irt_is_link_cfg = (a == OFS_CLOCK_RATIO_CONFIG) ||
      (a == OFS_LINK_RATE_FFE_CONFIG) || (a == OFS_SOURCE_TEST_CONFIG) ||
      (a == OFS_TRAINING_STATUS_LANES01) ||
      (a == OFS_TRAINING_STATUS_LANES23);
  endfunction

endpackage
`default_nettype wire

/* hw/irt_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module irt_sync #(
  parameter int WIDTH = 4,
  parameter int STAGES = 2
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  if (STAGES < 2) begin : g_bad
    $error("irt_sync needs at least two stages");
  end

  logic [WIDTH-1:0] stage [STAGES];

  // first stage is read only by the second one
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < STAGES; i++) stage[i] <= '1;
    end else if (ce_i) begin
      stage[0] <= async_i;
      for (int i = 1; i < STAGES; i++) stage[i] <= stage[i-1];
    end
  end

  assign sync_o = stage[STAGES-1];

endmodule // irt_sync
`default_nettype wire

/* hw/irt_regfile.sv */
`timescale 1ns/1ns
`default_nettype none
module irt_regfile
  import irt_pkg::*;
#(
  parameter int DEPTH = 128,
  parameter logic [7:0] REVISION = 8'h01 // arbitrary value
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [7:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] raddr_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] standby_status_i,
  input wire logic [7:0] aeq_result_a_i,
  input wire logic [7:0] aeq_result_b_i,
  output logic [7:0] pd_ctrl_o,
  output logic [7:0] misc_ctrl_o,
  output logic [7:0] global_config_o,
  output logic [7:0] lane_enables_o
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH <= int'(OFS_ADAPTIVE_EQ_RESULT_B) || DEPTH > 256) begin : g_bad
    $error("irt_regfile depth cannot hold the register map");
  end

  logic [7:0] mem [DEPTH];
  logic soft_all;
  logic soft_link;

  // pulse-high bits act at the write and are never stored
  assign soft_all = we_i && waddr_i == OFS_POWER_DOWN_RESET_CTRL &&
    wdata_i[PD_SOFT_RESET_BIT];
  assign soft_link = we_i && waddr_i == OFS_POWER_DOWN_RESET_CTRL &&
    wdata_i[PD_SCDC_RESET_BIT];

  ////////////////////////////////////////////////////////////////////////
  // storage; reserved and read-only offsets have an all-zero write mask
  always_ff @(posedge clk_i) begin
    if (srst_i || (ce_i && soft_all)) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= irt_reset(8'(i));
    end else if (ce_i) begin
      if (we_i) begin
        mem[waddr_i[AW-1:0]] <=
          (mem[waddr_i[AW-1:0]] & ~irt_wmask(waddr_i)) |
          (wdata_i & irt_wmask(waddr_i));
      end
      // a link reset still lets the other bits of its own write land
      if (soft_link) begin
        for (int i = 0; i < DEPTH; i++) begin
          if (irt_is_link_cfg(8'(i))) mem[i] <= irt_reset(8'(i));
        end
      end
    end
  end

  // registered read; status offsets show live hardware values
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= RST_OTHER;
    end else if (ce_i) begin
      case (raddr_i)
        OFS_REVISION_ID: rdata_o <= REVISION;
        OFS_POWER_STANDBY_STATUS: rdata_o <= standby_status_i;
        OFS_ADAPTIVE_EQ_RESULT_A: rdata_o <= aeq_result_a_i;
        OFS_ADAPTIVE_EQ_RESULT_B: rdata_o <= aeq_result_b_i;
        default: begin
          if (irt_wmask(raddr_i) != 8'h00) rdata_o <= mem[raddr_i[AW-1:0]];
          else rdata_o <= RST_OTHER;
        end
      endcase
    end
  end

  assign pd_ctrl_o = mem[OFS_POWER_DOWN_RESET_CTRL[AW-1:0]];
  assign misc_ctrl_o = mem[OFS_MISCELLANEOUS_CTRL[AW-1:0]];
  assign global_config_o = mem[OFS_GLOBAL_CONFIG[AW-1:0]];
  assign lane_enables_o = mem[OFS_LANE_ENABLES[AW-1:0]];

endmodule // irt_regfile
`default_nettype wire

/* hw/irt_i2c_target.sv */
`timescale 1ns/1ns
`default_nettype none
module irt_i2c_target
  import irt_pkg::*;
#(
  parameter int SYNC_STAGES = 2,
  parameter int REG_DEPTH = 128,
  parameter logic [7:0] REVISION = 8'h01 // arbitrary value
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic serial_clock_strap0_i,
  input wire logic serial_data_strap1_i,
  output logic serial_data_strap1_o,
  output logic serial_data_strap1_oe_o,
  input wire logic [1:0] address_strap_pin_i,
  input wire logic [7:0] standby_status_i,
  input wire logic [7:0] aeq_result_a_i,
  input wire logic [7:0] aeq_result_b_i,
  output logic [7:0] pd_ctrl_o,
  output logic [7:0] misc_ctrl_o,
  output logic [7:0] global_config_o,
  output logic [7:0] lane_enables_o,
  output logic busy_o
);

  ////////////////////////////////////////////////////////////////////////
  // parameter checks; the strap settle counter is four bits wide

  if (SYNC_STAGES < 2 || SYNC_STAGES > 15) begin : g_bad
    $error("irt_i2c_target needs 2 to 15 sync stages");
  end

  ////////////////////////////////////////////////////////////////////////
  // declarations

  logic [3:0] pins_sync;
  logic scl;
  logic sda;
  logic [1:0] strap;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  logic strap_taken;
  // edges waited after reset before the strap level is trusted
  logic [3:0] strap_wait;
  logic [6:0] own_addr;

  irt_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic read_dir;
  logic ctrl_ack;
  logic [7:0] pointer;

  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  logic addr_match;
  logic byte_done;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: scl, sda and the two strap level bits
  // one shared chain keeps scl and sda in step, so skew between the
  // two can never turn a data bit into a start or a stop

  irt_sync #(
    .WIDTH(4),
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .async_i({address_strap_pin_i, serial_data_strap1_i,
      serial_clock_strap0_i}),
    .sync_o(pins_sync)
  );

  assign scl = pins_sync[0];
  assign sda = pins_sync[1];
  assign strap = pins_sync[3:2];

  ////////////////////////////////////////////////////////////////////////
  // register storage and read port

  irt_regfile #(
    .DEPTH(REG_DEPTH),
    .REVISION(REVISION)
  ) u_regs (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .we_i(wr_en),
    .waddr_i(wr_addr),
    .wdata_i(wr_data),
    .raddr_i(pointer),
    .rdata_o(rd_data),
    .standby_status_i(standby_status_i),
    .aeq_result_a_i(aeq_result_a_i),
    .aeq_result_b_i(aeq_result_b_i),
    .pd_ctrl_o(pd_ctrl_o),
    .misc_ctrl_o(misc_ctrl_o),
    .global_config_o(global_config_o),
    .lane_enables_o(lane_enables_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus edge and condition detection on the synchronised pins

  // delayed copies, idle-high so reset never fakes an edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (ce_i) begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  assign scl_rise = scl && !scl_d;
  assign scl_fall = !scl && scl_d;
  // sda moving while scl stays high marks start and stop
  assign start_seen = scl && scl_d && !sda && sda_d;
  assign stop_seen = scl && scl_d && sda && !sda_d;

  ////////////////////////////////////////////////////////////////////////
  // strap capture, taken once after reset release; the synchroniser
  // holds its all-ones reset fill for SYNC_STAGES edges, so the capture
  // waits them out; later strap moves are ignored

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      strap_taken <= 1'b0;
      strap_wait <= 4'h0;
      own_addr <= TADDR_LOW;
    end else if (ce_i && !strap_taken &&
        strap_wait != 4'(SYNC_STAGES)) begin
      // reading the strap now would see the reset fill, not the pin
      strap_wait <= strap_wait + 4'h1;
    end else if (ce_i && !strap_taken) begin
      strap_taken <= 1'b1;
      case (strap)
        STRAP_LOW: own_addr <= TADDR_LOW;
        STRAP_RES: own_addr <= TADDR_RES;
        STRAP_FLOAT: own_addr <= TADDR_FLOAT;
        STRAP_HIGH: own_addr <= TADDR_HIGH;
        default: own_addr <= TADDR_LOW;
      endcase
    end
  end

  // bit 0 of the received byte is the direction, not part of the address
  assign addr_match = shift_in[7:1] == own_addr;
  assign byte_done = bit_cnt == BYTE_BITS;

  ////////////////////////////////////////////////////////////////////////
  // receive shifter and bit counter; bits are sampled on scl rise

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      shift_in <= 8'h00;
      bit_cnt <= 4'h0;
    end else if (ce_i) begin
      if (start_seen || stop_seen) begin
        bit_cnt <= 4'h0;
      end else if (scl_fall && byte_done) begin
        bit_cnt <= 4'h0;
      end else if (scl_rise && (state == ST_ADDR || state == ST_OFFS ||
          state == ST_WDATA || state == ST_RDATA)) begin
        shift_in <= {shift_in[6:0], sda}; // msb first
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  // controller acknowledge, sampled on the ninth rise of a read byte
  // it is taken afresh for every byte, so no stale value carries over
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_ack <= 1'b0;
    end else if (ce_i && state == ST_RACK && scl_rise) begin
      ctrl_ack <= !sda;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transaction state; start and stop override every state so that a
  // repeated start can turn a write into a read at any point

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= ST_IDLE;
      read_dir <= 1'b0;
    end else if (ce_i) begin
      if (start_seen) begin
        state <= ST_ADDR;
      end else if (stop_seen) begin
        state <= ST_IDLE;
      end else if (scl_fall) begin
        case (state)
          ST_ADDR: begin
            if (byte_done) begin
              read_dir <= shift_in[0];
              // foreign address: stay silent until the next start
              state <= addr_match ? ST_ADDR_ACK : ST_IDLE;
            end
          end
          ST_ADDR_ACK: state <= read_dir ? ST_RDATA : ST_OFFS;
          ST_OFFS: if (byte_done) state <= ST_OFFS_ACK;
          ST_OFFS_ACK: state <= ST_WDATA;
          ST_WDATA: if (byte_done) state <= ST_WDATA_ACK;
          ST_WDATA_ACK: state <= ST_WDATA;
          ST_RDATA: if (byte_done) state <= ST_RACK;
          ST_RACK: state <= ctrl_ack ? ST_RDATA : ST_WAIT_STOP;
          ST_WAIT_STOP: state <= ST_WAIT_STOP;
          ST_IDLE: state <= ST_IDLE;
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register pointer: loaded by the offset byte, kept across
  // transactions, stepped after each written and each read byte

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pointer <= RST_POINTER;
    end else if (ce_i && scl_fall && byte_done) begin
      case (state)
        ST_OFFS: pointer <= shift_in;
        ST_WDATA: pointer <= pointer + 8'h01;
        // advances whether or not the controller then acknowledges
        ST_RDATA: pointer <= pointer + 8'h01;
        default: pointer <= pointer;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register write strobe: one cycle, at the fall after a data byte;
  // an offset-only transaction never raises it

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_en <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else if (ce_i) begin
      wr_en <= scl_fall && byte_done && state == ST_WDATA;
      wr_addr <= pointer;
      wr_data <= shift_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit shifter; read data is fetched from the pointer, which was
  // settled several cycles before the fall that loads it

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      shift_out <= 8'hFF;
    end else if (ce_i && scl_fall) begin
      if ((state == ST_ADDR_ACK && read_dir) ||
          (state == ST_RACK && ctrl_ack)) begin
        shift_out <= rd_data;
      end else if (state == ST_RDATA && !byte_done) begin
        // ones fill in, so a stray extra fall leaves sda released
        shift_out <= {shift_out[6:0], 1'b1};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sda driver; open drain, so the output level is always low and only
  // the enable moves. changes happen after scl falls, and a start or stop
  // only clears the enable, which keeps sda stable across every data high phase

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      serial_data_strap1_o <= 1'b0;
      serial_data_strap1_oe_o <= 1'b0;
    end else if (ce_i) begin
      serial_data_strap1_o <= 1'b0;
      if (start_seen || stop_seen) begin
        serial_data_strap1_oe_o <= 1'b0;
      end else if (scl_fall) begin
        case (state)
          ST_ADDR: serial_data_strap1_oe_o <= byte_done && addr_match;
          ST_ADDR_ACK: serial_data_strap1_oe_o <= read_dir && !rd_data[7];
          ST_OFFS: serial_data_strap1_oe_o <= byte_done;
          ST_WDATA: serial_data_strap1_oe_o <= byte_done;
          ST_RDATA: begin
            // release for the controller's acknowledge slot
            if (byte_done) serial_data_strap1_oe_o <= 1'b0;
            else serial_data_strap1_oe_o <= !shift_out[6];
          end
          ST_RACK: serial_data_strap1_oe_o <= ctrl_ack && !rd_data[7];
          default: serial_data_strap1_oe_o <= 1'b0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // busy flag: high from our address acknowledge until the next start or stop
  // a foreign address never raises it, so it marks our own traffic only

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      busy_o <= 1'b0;
    end else if (ce_i) begin
      busy_o <= state != ST_IDLE && state != ST_ADDR;
    end
  end

endmodule // irt_i2c_target
`default_nettype wire

/* tb/irt_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
// pin and register watch on the target, one clock domain
module irt_assertions (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic serial_clock_strap0_i,
  input wire logic serial_data_strap1_i,
  input wire logic serial_data_strap1_oe_o,
  input wire logic [7:0] pd_ctrl_o,
  input wire logic [7:0] misc_ctrl_o,
  input wire logic [7:0] global_config_o,
  input wire logic [7:0] lane_enables_o,
  input wire logic busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////////////////////////////////////
  // reset leaves documented values and a released bus
  reset_state_a: assert property ($fell(srst_i) |->
    pd_ctrl_o == 8'h01 && misc_ctrl_o == 8'h08 && lane_enables_o == 8'h00
    && global_config_o == 8'h00 && !busy_o && !serial_data_strap1_oe_o)
    else $error("bad state after reset");
  // past scl guards against our own late release looking like a stop
  stop_idle_a: assert property (serial_clock_strap0_i &&
    $past(serial_clock_strap0_i) && $rose(serial_data_strap1_i)
    |-> ##[1:6] !busy_o) else $error("busy after stop");
  start_free_a: assert property (serial_clock_strap0_i &&
    $past(serial_clock_strap0_i) && $fell(serial_data_strap1_i)
    |-> !serial_data_strap1_oe_o) else $error("sda held at start");
  // sda drive may only move while scl is low
  oe_hold_a: assert property (serial_clock_strap0_i [*3] |->
    $stable(serial_data_strap1_oe_o)) else $error("sda moved, scl high");
  // registers move only inside an addressed transaction
  misc_quiet_a: assert property ($changed(misc_ctrl_o) |-> busy_o)
    else $error("misc changed while idle");
  lane_quiet_a: assert property ($changed(lane_enables_o) |-> busy_o)
    else $error("lanes changed while idle");
  glob_quiet_a: assert property ($changed(global_config_o) |-> busy_o)
    else $error("global changed while idle");
  pd_quiet_a: assert property ($changed(pd_ctrl_o) |-> busy_o)
    else $error("power ctrl changed while idle");
endmodule // irt_assertions

bind irt_i2c_target irt_assertions irt_assertions_i (.clk_i(clk_i),
  .srst_i(srst_i), .serial_clock_strap0_i(serial_clock_strap0_i),
  .serial_data_strap1_i(serial_data_strap1_i),
  .serial_data_strap1_oe_o(serial_data_strap1_oe_o),
  .pd_ctrl_o(pd_ctrl_o), .misc_ctrl_o(misc_ctrl_o),
  .global_config_o(global_config_o), .lane_enables_o(lane_enables_o),
  .busy_o(busy_o));
`default_nettype wire

/* tb/irt_i2c_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
// bit-banged bus controller; scl rests high between frames
module irt_i2c_ctrl (
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  localparam int Q = 200; // quarter of the 800 ns bit period
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  // one bit: data set while scl low, sampled mid scl high
  task automatic xbit(input logic b, output logic r);
    sda_o = b;
    #Q scl_o = 1'b1;
    #Q r = sda_i;
    #Q scl_o = 1'b0;
    #Q;
  endtask
  // start from idle, or repeated start from scl low
  task automatic start();
    sda_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b1;
    #(2 * Q);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(d[i], r);
    xbit(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
    xbit(nack, r);
  endtask
endmodule // irt_i2c_ctrl
`default_nettype wire

/* tb/i2c_register_target_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module i2c_register_target_tb_top;
  localparam logic [7:0] REV = 8'h5A; // arbitrary revision value
  logic clk;
  logic srst = 1'b1;
  logic [1:0] strap = 2'h0;
  logic [7:0] standby = 8'h00, aeq_a = 8'h00, aeq_b = 8'h00;
  logic scl, sda_drv, oe, sdo;
  logic [7:0] pd, misc, glob, lane, ptr;
  wire logic sda;
  logic [6:0] adr [4] = '{7'h5E, 7'h5D, 7'h5C, 7'h5B};
  logic [6:0] ta;
  logic [7:0] mem [256];
  int failures = 0, cmp_count = 0, cyc = 0;
  // pull-up: high unless a party pulls low
  assign sda = sda_drv & (oe ? sdo : 1'b1);
  irt_i2c_target #(.REVISION(REV)) irt_i2c_target_i (.clk_i(clk),
    .srst_i(srst), .ce_i(1'b1), .serial_clock_strap0_i(scl),
    .serial_data_strap1_i(sda), .serial_data_strap1_o(sdo),
    .serial_data_strap1_oe_o(oe), .address_strap_pin_i(strap),
    .standby_status_i(standby), .aeq_result_a_i(aeq_a),
    .aeq_result_b_i(aeq_b), .pd_ctrl_o(pd), .misc_ctrl_o(misc),
    .global_config_o(glob), .lane_enables_o(lane), .busy_o());
  irt_i2c_ctrl irt_i2c_ctrl_i (.scl_o(scl), .sda_o(sda_drv), .sda_i(sda));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  // writable bits per offset; zero for read-only and reserved places
  function automatic logic [7:0] wm(input logic [7:0] a);
    if (a == 8'h09) return 8'h17;
    if (a inside {[8'h0A:8'h0E], [8'h11:8'h1A], 8'h1D, 8'h1E, 8'h20,
        8'h31, 8'h35, 8'h41, 8'h42}) return 8'hFF;
    return 8'h00;
  endfunction
  function automatic logic [7:0] ex(input logic [7:0] a);
    case (a)
      8'h1C: return standby;
      8'h50: return aeq_a;
      8'h51: return aeq_b;
      default: return mem[a];
    endcase
  endfunction
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // strap must settle well before release, it is latched three clocks after
  task automatic do_reset(input logic [1:0] s);
    strap = s;
    srst = 1'b1;
    repeat (16) @(posedge clk);
    #2 srst = 1'b0;
    repeat (4) @(posedge clk);
    #2;
    clear_mem();
    ptr = 8'h00;
  endtask
  // register contents after any reset
  task automatic clear_mem();
    foreach (mem[i]) mem[i] = 8'h00;
    mem[8'h08] = REV;
    mem[8'h09] = 8'h01;
    mem[8'h0A] = 8'h08;
  endtask
  // offset 09h pulse bits: 7 resets every register, 6 the link config
  task automatic pulse(input logic [7:0] d);
    logic k;
    irt_i2c_ctrl_i.start();
    irt_i2c_ctrl_i.wbyte({ta, 1'b0}, k);
    irt_i2c_ctrl_i.wbyte(8'h09, k);
    irt_i2c_ctrl_i.wbyte(d, k);
    chk1(k, 1'b1);
    irt_i2c_ctrl_i.stop();
    ptr = 8'h0A;
    if (d[7]) clear_mem();
    else mem[8'h09] = d & 8'h17;
    if (d[6]) {mem[8'h20], mem[8'h31], mem[8'h35], mem[8'h41],
      mem[8'h42]} = 40'h00;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] o, input int n,
      input logic ok, input logic sr);
    logic k;
    logic [7:0] d;
    irt_i2c_ctrl_i.start();
    irt_i2c_ctrl_i.wbyte({a, 1'b0}, k);
    chk1(k, ok);
    irt_i2c_ctrl_i.wbyte(o, k);
    chk1(k, ok);
    if (ok) ptr = o;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom()) & ((ptr == 8'h09) ? 8'h17 : 8'hFF);
      irt_i2c_ctrl_i.wbyte(d, k);
      chk1(k, 1'b1);
      mem[ptr] = (mem[ptr] & ~wm(ptr)) | (d & wm(ptr));
      ptr++;
    end
    if (!sr) irt_i2c_ctrl_i.stop();
  endtask
  // read n bytes, nack the last, then clock one more byte
  task automatic rd(input int n);
    logic k;
    logic [7:0] d;
    irt_i2c_ctrl_i.start();
    irt_i2c_ctrl_i.wbyte({ta, 1'b1}, k);
    chk1(k, 1'b1);
    for (int i = 0; i < n; i++) begin
      irt_i2c_ctrl_i.rbyte(i == n - 1, d);
      chk8(d, ex(ptr));
      ptr++;
    end
    irt_i2c_ctrl_i.rbyte(1'b1, d);
    chk8(d, 8'hFF);
    irt_i2c_ctrl_i.stop();
  endtask
  // hang guard, about 1.7 times the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 50000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    logic [7:0] o;
    int n;
    void'($urandom(32'h6C08A1D9));
    for (int s = 0; s < 4; s++) begin
      ta = adr[s];
      do_reset(2'(s));
      rd(12);
      wr(adr[(s + 1) % 4], 8'h1D, 0, 1'b0, 1'b0);
      rd(2);
      wr(ta, 8'h08, 3, 1'b1, 1'b0);
      wr(ta, 8'h0D, 2, 1'b1, 1'b0);
      wr(ta, 8'h11, 1, 1'b1, 1'b0);
      wr(ta, 8'h08, 0, 1'b1, 1'b0);
      rd(3);
      repeat (3) begin
        do o = 8'h08 + 8'($urandom_range(58)); while (wm(o) == 8'h00);
        n = 1;
        while (n < 4 && wm(o + 8'(n)) != 8'h00) n++;
        wr(ta, o, n, 1'b1, 1'b0);
        wr(ta, o, 0, 1'b1, 1'b1);
        rd(n);
      end
      standby = 8'($urandom());
      aeq_a = 8'($urandom());
      aeq_b = 8'($urandom());
      wr(ta, 8'h1C, 0, 1'b1, 1'b0);
      rd(1);
      wr(ta, 8'h50, 0, 1'b1, 1'b0);
      rd(2);
      wr(ta, 8'h20, 1, 1'b1, 1'b0);
      pulse(8'h40 | (8'($urandom()) & 8'h17));
      wr(ta, 8'h20, 0, 1'b1, 1'b1);
      rd(1);
      chk8(pd, mem[8'h09]);
      chk8(misc, mem[8'h0A]);
      chk8(glob, mem[8'h0D]);
      chk8(lane, mem[8'h11]);
      pulse(8'h80);
      chk8(pd, mem[8'h09]);
      chk8(misc, mem[8'h0A]);
      $display("strap %0d test done", s);
    end
    complete_run();
  end
endmodule // i2c_register_target_tb_top
`default_nettype wire
